// *** hw/tec_top.v ***
// transient event counter control with its AHB-Lite register slave
`include "tec_defs.vh"
`default_nettype none

// Contract
// - start/stop toggles stopped/running; timer counts only while running
// - count rate cycles 7, 8, 100 per second; caps events per second
// - run time 0 to 9999 minutes; zero means no limit
// - run time up/down keys move by five minutes
// - low impulse threshold 30 to 110 dBrn, 1 dBrn per key
// - step cycles 2..6 dB; mid is low plus step, high is mid plus step
// - phase threshold cycles 5..45 degrees in steps of five
// - gain threshold cycles 2..10 dB in steps of one
// - noise filter choice feeds impulse detection only
// - six separate counters: three impulse levels, phase, gain, dropouts
// - noise-with-tone reading follows its input while stopped
// - noise-with-tone reading frozen while running
// - elapsed non-zero run time stops the measurement
// - any setting change restarts: time and counts cleared, counting anew
// - counters and elapsed time stay readable during a run
// - entering the transients function selects the 1004 Hz holding tone
module tec_top #(
	parameter SEC_CYCLES = `TEC_CLK_HZ * `TEC_TICK_S,
	parameter CW = 16,
	parameter NW = 8
) (
	input wire MCLK, // system clock, 50 MHz
	input wire RESET, // synchronous reset, high
	input wire HSEL, // slave select
	input wire [31:0] HADDR, // byte address
	input wire [1:0] HTRANS, // transfer type
	input wire HWRITE, // write when high
	input wire [2:0] HSIZE, // transfer size
	input wire [31:0] HWDATA, // write data
	input wire HREADY, // bus ready in
	output reg [31:0] HRDATA, // read data
	output wire HREADYOUT, // always ready
	output wire HRESP, // always OKAY
	input wire IMP_LO_HIT, // impulse over low threshold
	input wire IMP_MID_HIT, // impulse over mid threshold
	input wire IMP_HI_HIT, // impulse over high threshold
	input wire PHASE_HIT, // phase jump detected
	input wire GAIN_HIT, // gain jump detected
	input wire DROPOUT_HIT, // dropout detected
	input wire [NW-1:0] NWT_LEVEL, // live noise-with-tone, dBrn
	output reg [6:0] IMP_LOW_THR, // low impulse threshold, dBrn
	output reg [6:0] IMP_MID_THR, // mid impulse threshold, dBrn
	output reg [6:0] IMP_HIGH_THR, // high impulse threshold, dBrn
	output reg [2:0] IMP_FILTER, // weighting filter, impulse path
	output reg [5:0] PHASE_THR, // phase jump threshold, degrees
	output reg [3:0] GAIN_THR, // gain jump threshold, dB
	output reg HOLD_TONE, // transmit 1004 Hz holding tone
	output reg RUNNING // measurement running
);

	localparam ST_STOP = 2'b01;
	localparam ST_RUN = 2'b10;
	reg [1:0] state, next_state;
	reg func_on;
	reg [13:0] time_limit;
	reg [6:0] impulse_low_threshold;
	reg [2:0] impulse_threshold_increment;
	reg [5:0] phase_jump_threshold;
	reg [3:0] gain_jump_threshold;
	reg [1:0] rate_sel;
	reg [6:0] rate;
	reg [2:0] filt;
	reg [31:0] sec_div;
	reg sec_tick;
	reg [5:0] el_sec;
	reg [13:0] el_min;
	reg [NW-1:0] nwt_hold;
	reg [NW-1:0] nwt_s1, nwt_s2, nwt_s3;
	reg wr_pend;
	reg [7:0] wr_addr;
	reg [31:0] next_rdata;
	reg restart, limit_hit;
	wire addr_ok, key_wr, ctrl_wr;
	wire [3:0] key_code;
	wire [13:0] key_data;
	wire [5:0] hits;
	wire [6*CW-1:0] counts;
	wire run_now;
	wire start_now = (state == ST_STOP) && (next_state == ST_RUN);

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign addr_ok = HSEL & HTRANS[1] & HREADY;

	// capture write address phase
	always @(posedge MCLK) begin
		if (RESET) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok & HWRITE;
			wr_addr <= HADDR[7:0];
		end
	end

	assign ctrl_wr = wr_pend & (wr_addr == `TEC_OFS_CTRL);
	assign key_wr = wr_pend & (wr_addr == `TEC_OFS_KEY);
	assign key_code = HWDATA[3:0];
	assign key_data = HWDATA[`TEC_KEY_DATA_LSB+13:`TEC_KEY_DATA_LSB];

	// function select and holding tone
	always @(posedge MCLK) begin
		if (RESET) begin
			func_on <= 1'b0;
			HOLD_TONE <= 1'b0;
		end else if (ctrl_wr) begin
			func_on <= HWDATA[`TEC_CTRL_FUNC];
			HOLD_TONE <= HWDATA[`TEC_CTRL_FUNC];
		end
	end

	// settings driven by key actions
	always @(posedge MCLK) begin
		if (RESET) begin
			time_limit <= `TEC_TIME_RST;
			impulse_low_threshold <= `TEC_LOW_RST;
			impulse_threshold_increment <= `TEC_STEP_RST;
			phase_jump_threshold <= `TEC_PH_RST;
			gain_jump_threshold <= `TEC_GN_RST;
			rate_sel <= 2'h0;
			filt <= `TEC_FILT_RST;
		end else if (key_wr) begin
			case (key_code)
			`TEC_KEY_RATE:
				rate_sel <= (rate_sel == 2'h2) ? 2'h0 : rate_sel + 2'h1;
			`TEC_KEY_TIME_UP:
				if (time_limit > `TEC_TIME_MAX - `TEC_TIME_STEP)
					time_limit <= `TEC_TIME_MAX;
				else
					time_limit <= time_limit + `TEC_TIME_STEP;
			`TEC_KEY_TIME_DN:
				if (time_limit < `TEC_TIME_STEP)
					time_limit <= 14'h0000;
				else
					time_limit <= time_limit - `TEC_TIME_STEP;
			`TEC_KEY_TIME_LD:
				if (key_data > `TEC_TIME_MAX)
					time_limit <= `TEC_TIME_MAX;
				else
					time_limit <= key_data;
			`TEC_KEY_LOW_UP:
				if (impulse_low_threshold < `TEC_LOW_MAX)
					impulse_low_threshold <= impulse_low_threshold + 7'h01;
			`TEC_KEY_LOW_DN:
				if (impulse_low_threshold > `TEC_LOW_MIN)
					impulse_low_threshold <= impulse_low_threshold - 7'h01;
			`TEC_KEY_LOW_LD:
				if (key_data < {7'h00, `TEC_LOW_MIN})
					impulse_low_threshold <= `TEC_LOW_MIN;
				else if (key_data > {7'h00, `TEC_LOW_MAX})
					impulse_low_threshold <= `TEC_LOW_MAX;
				else
					impulse_low_threshold <= key_data[6:0];
			`TEC_KEY_STEP:
				if (impulse_threshold_increment == `TEC_STEP_MAX)
					impulse_threshold_increment <= `TEC_STEP_MIN;
				else
					impulse_threshold_increment <=
						impulse_threshold_increment + 3'h1;
			`TEC_KEY_PHASE:
				if (phase_jump_threshold == `TEC_PH_MAX)
					phase_jump_threshold <= `TEC_PH_MIN;
				else
					phase_jump_threshold <=
						phase_jump_threshold + `TEC_PH_STEP;
			`TEC_KEY_GAIN:
				if (gain_jump_threshold == `TEC_GN_MAX)
					gain_jump_threshold <= `TEC_GN_MIN;
				else
					gain_jump_threshold <= gain_jump_threshold + 4'h1;
			`TEC_KEY_FILT:
				if (key_data[2:0] <= `TEC_FILT_MAX)
					filt <= key_data[2:0];
			default: filt <= filt;
			endcase
		end
	end

	// a valid key action restarts the run
	always @* begin
		restart = 1'b0;
		if (key_wr && key_code >= `TEC_KEY_RATE && key_code <= `TEC_KEY_FILT)
			restart = 1'b1;
	end

	// rate choice decode
	always @* begin
		case (rate_sel)
		2'h0: rate = `TEC_RATE_A;
		2'h1: rate = `TEC_RATE_B;
		default: rate = `TEC_RATE_C;
		endcase
	end

	// thresholds and filter out to the detectors
	always @(posedge MCLK) begin
		if (RESET) begin
			IMP_LOW_THR <= `TEC_LOW_RST;
			IMP_MID_THR <= `TEC_LOW_RST + {4'h0, `TEC_STEP_RST};
			IMP_HIGH_THR <= `TEC_LOW_RST + {3'h0, `TEC_STEP_RST, 1'b0};
			IMP_FILTER <= `TEC_FILT_RST;
			PHASE_THR <= `TEC_PH_RST;
			GAIN_THR <= `TEC_GN_RST;
		end else begin
			IMP_LOW_THR <= impulse_low_threshold;
			IMP_MID_THR <= impulse_low_threshold +
				{4'h0, impulse_threshold_increment};
			IMP_HIGH_THR <= impulse_low_threshold +
				{3'h0, impulse_threshold_increment, 1'b0};
			IMP_FILTER <= filt;
			PHASE_THR <= phase_jump_threshold;
			GAIN_THR <= gain_jump_threshold;
		end
	end

	// limit reached at the last second of the last minute
	always @* begin
		limit_hit = 1'b0;
		if (time_limit != 14'h0000 && sec_tick && el_sec == `TEC_SEC_PER_MIN
			&& el_min + 14'h0001 >= time_limit)
			limit_hit = 1'b1;
	end

	// start/stop state machine
	always @* begin
		next_state = state;
		case (state)
		ST_STOP: begin
			if (ctrl_wr && HWDATA[`TEC_CTRL_TOGGLE] && func_on &&
				HWDATA[`TEC_CTRL_FUNC])
				next_state = ST_RUN;
		end
		ST_RUN: begin
			if (ctrl_wr && HWDATA[`TEC_CTRL_TOGGLE])
				next_state = ST_STOP;
			else if (ctrl_wr && !HWDATA[`TEC_CTRL_FUNC])
				next_state = ST_STOP;
			else if (limit_hit && !restart)
				next_state = ST_STOP;
		end
		default: next_state = ST_STOP;
		endcase
	end

	always @(posedge MCLK) begin
		if (RESET) begin
			state <= ST_STOP;
			RUNNING <= 1'b0;
		end else begin
			state <= next_state;
			RUNNING <= (next_state == ST_RUN);
		end
	end

	assign run_now = (state == ST_RUN);

	// one-second time base, realigned on start and restart
	always @(posedge MCLK) begin
		if (RESET || restart || !run_now) begin
			sec_div <= 32'h00000000;
			sec_tick <= 1'b0;
		end else if (sec_div == SEC_CYCLES - 1) begin
			sec_div <= 32'h00000000;
			sec_tick <= 1'b1;
		end else begin
			sec_div <= sec_div + 32'h00000001;
			sec_tick <= 1'b0;
		end
	end

	// elapsed time; cleared on start and on restart, kept on stop
	always @(posedge MCLK) begin
		if (RESET || restart || start_now) begin
			el_sec <= 6'h00;
			el_min <= 14'h0000;
		end else if (run_now && sec_tick) begin
			if (el_sec == `TEC_SEC_PER_MIN) begin
				el_sec <= 6'h00;
				if (el_min != `TEC_TIME_MAX)
					el_min <= el_min + 14'h0001;
			end else begin
				el_sec <= el_sec + 6'h01;
			end
		end
	end

	// noise-with-tone: taken once two synced samples agree, frozen running
	always @(posedge MCLK) begin
		if (RESET) begin
			nwt_s1 <= {NW{1'b0}};
			nwt_s2 <= {NW{1'b0}};
			nwt_s3 <= {NW{1'b0}};
			nwt_hold <= {NW{1'b0}};
		end else begin
			nwt_s1 <= NWT_LEVEL;
			nwt_s2 <= nwt_s1;
			nwt_s3 <= nwt_s2;
			if (!run_now && nwt_s2 == nwt_s3)
				nwt_hold <= nwt_s2;
		end
	end

	// six event channels
	assign hits = {DROPOUT_HIT, GAIN_HIT, PHASE_HIT,
		IMP_HI_HIT, IMP_MID_HIT, IMP_LO_HIT};
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_ch
			tec_evt_cnt #(
				.CW(CW)
			) u_cnt (
				.clk(MCLK),
				.rst(RESET),
				.evt_pin(hits[gi]),
				.run(run_now),
				.clear(restart | start_now),
				.sec_tick(sec_tick),
				.rate(rate),
				.count(counts[gi*CW +: CW])
			);
		end
	endgenerate

	// read data chosen in the address phase
	always @* begin
		next_rdata = 32'h00000000;
		case (HADDR[7:0])
		`TEC_OFS_CTRL: next_rdata = {30'h00000000, func_on, run_now};
		`TEC_OFS_THR: next_rdata = {5'h00, impulse_threshold_increment,
			1'b0, IMP_HIGH_THR, 1'b0, IMP_MID_THR, 1'b0,
			impulse_low_threshold};
		`TEC_OFS_SET: next_rdata = {4'h0, gain_jump_threshold, 2'h0,
			phase_jump_threshold, 2'h0, time_limit};
		`TEC_OFS_RATE: next_rdata = {21'h000000, filt, 1'b0, rate};
		`TEC_OFS_TIME: next_rdata = {10'h000, el_sec, 2'h0, el_min};
		`TEC_OFS_CNT0: next_rdata = {{(32-CW){1'b0}}, counts[0 +: CW]};
		`TEC_OFS_CNT0 + 8'h04:
			next_rdata = {{(32-CW){1'b0}}, counts[CW +: CW]};
		`TEC_OFS_CNT0 + 8'h08:
			next_rdata = {{(32-CW){1'b0}}, counts[2*CW +: CW]};
		`TEC_OFS_CNT0 + 8'h0C:
			next_rdata = {{(32-CW){1'b0}}, counts[3*CW +: CW]};
		`TEC_OFS_CNT0 + 8'h10:
			next_rdata = {{(32-CW){1'b0}}, counts[4*CW +: CW]};
		`TEC_OFS_CNT0 + 8'h14:
			next_rdata = {{(32-CW){1'b0}}, counts[5*CW +: CW]};
		`TEC_OFS_NWT: next_rdata = {{(32-NW){1'b0}}, nwt_hold};
		default: next_rdata = 32'h00000000;
		endcase
	end

	// read data register, loaded on a read address phase
	always @(posedge MCLK) begin
		if (RESET)
			HRDATA <= 32'h00000000;
		else if (addr_ok && !HWRITE)
			HRDATA <= next_rdata;
	end

endmodule // tec_top

`default_nettype wire

// *** hw/tec_defs.vh ***
// constants for the transient event counter control block
`ifndef TEC_DEFS_VH
`define TEC_DEFS_VH

// time base
`define TEC_CLK_HZ 32'h02FAF080
`define TEC_TICK_S 32'h00000001
`define TEC_SEC_PER_MIN 6'h3B

// register byte offsets
`define TEC_OFS_CTRL 8'h00
`define TEC_OFS_KEY 8'h04
`define TEC_OFS_THR 8'h08
`define TEC_OFS_SET 8'h0C
`define TEC_OFS_RATE 8'h10
`define TEC_OFS_TIME 8'h14
`define TEC_OFS_CNT0 8'h18
`define TEC_OFS_NWT 8'h30

// control register bits
`define TEC_CTRL_TOGGLE 0
`define TEC_CTRL_FUNC 1

// key action codes and data field
`define TEC_KEY_RATE 4'h1
`define TEC_KEY_TIME_UP 4'h2
`define TEC_KEY_TIME_DN 4'h3
`define TEC_KEY_TIME_LD 4'h4
`define TEC_KEY_LOW_UP 4'h5
`define TEC_KEY_LOW_DN 4'h6
`define TEC_KEY_LOW_LD 4'h7
`define TEC_KEY_STEP 4'h8
`define TEC_KEY_PHASE 4'h9
`define TEC_KEY_GAIN 4'hA
`define TEC_KEY_FILT 4'hB
`define TEC_KEY_DATA_LSB 16

// setting ranges and reset values
`define TEC_TIME_MAX 14'h270F
`define TEC_TIME_STEP 14'h0005
`define TEC_TIME_RST 14'h0000
`define TEC_LOW_MIN 7'h1E
`define TEC_LOW_MAX 7'h6E
`define TEC_LOW_RST 7'h44
`define TEC_STEP_MIN 3'h2
`define TEC_STEP_MAX 3'h6
`define TEC_STEP_RST 3'h4
`define TEC_PH_MIN 6'h05
`define TEC_PH_MAX 6'h2D
`define TEC_PH_STEP 6'h05
`define TEC_PH_RST 6'h14
`define TEC_GN_MIN 4'h2
`define TEC_GN_MAX 4'hA
`define TEC_GN_RST 4'hA
`define TEC_RATE_A 7'h07
`define TEC_RATE_B 7'h08
`define TEC_RATE_C 7'h64
`define TEC_FILT_MAX 3'h4
`define TEC_FILT_RST 3'h0

`endif

// *** hw/tec_evt_cnt.v ***
// one event channel: pin synchroniser, edge detect, rate limit, counter
`default_nettype none

module tec_evt_cnt #(
	parameter CW = 16
) (
	input wire clk, // system clock
	input wire rst, // synchronous reset, high
	input wire evt_pin, // raw detector output, asynchronous
	input wire run, // counting allowed
	input wire clear, // restart: zero count and budget
	input wire sec_tick, // one-second boundary
	input wire [6:0] rate, // most events counted per second
	output reg [CW-1:0] count // events counted so far
);

	reg s1;
	reg s2;
	reg s3;
	reg [6:0] used;
	wire rise;
	wire room;

	// two-stage synchroniser plus one stage for the edge
	always @(posedge clk) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= evt_pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign rise = s2 & ~s3;
	assign room = (used < rate);

	// per-second budget and saturating count
	always @(posedge clk) begin
		if (rst || clear) begin
			used <= 7'h00;
			count <= {CW{1'b0}};
		end else begin
			if (sec_tick)
				used <= 7'h00;
			else if (run && rise && room)
				used <= used + 7'h01;
			if (run && rise && room && !sec_tick && count != {CW{1'b1}})
				count <= count + {{(CW-1){1'b0}}, 1'b1};
		end
	end

endmodule // tec_evt_cnt

`default_nettype wire

// *** bench/tec_chk_sva.sv ***
// checker for the transient event counter control ports
`default_nettype none

module tec_chk (
	input wire logic MCLK, // system clock
	input wire logic RESET, // synchronous reset
	input wire logic HREADYOUT, // bus ready out
	input wire logic HRESP, // bus response
	input wire logic HOLD_TONE, // holding tone on
	input wire logic RUNNING, // measurement running
	input wire logic [6:0] IMP_LOW_THR, // low threshold
	input wire logic [6:0] IMP_MID_THR, // mid threshold
	input wire logic [6:0] IMP_HIGH_THR, // high threshold
	input wire logic [5:0] PHASE_THR, // phase threshold
	input wire logic [3:0] GAIN_THR // gain threshold
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);

	// phase threshold sitting at its top, then moving
	sequence s_ph_top;
		PHASE_THR == 6'h2D ##1 $changed(PHASE_THR);
	endsequence

	// bus, threshold and holding tone relations
	property p_rdy; HREADYOUT; endproperty
	property p_okay; !HRESP; endproperty
	property p_low_rng;
		IMP_LOW_THR >= 7'h1E && IMP_LOW_THR <= 7'h6E;
	endproperty
	property p_ladder;
		IMP_HIGH_THR - IMP_MID_THR == IMP_MID_THR - IMP_LOW_THR;
	endproperty
	property p_step_rng;
		IMP_MID_THR >= IMP_LOW_THR + 7'h02 &&
			IMP_MID_THR <= IMP_LOW_THR + 7'h06;
	endproperty
	property p_ph_step;
		$changed(PHASE_THR) |-> PHASE_THR == ($past(PHASE_THR) == 6'h2D ?
			6'h05 : $past(PHASE_THR) + 6'h05);
	endproperty
	property p_ph_wrap; s_ph_top |-> PHASE_THR == 6'h05; endproperty
	property p_gn_step;
		$changed(GAIN_THR) |-> GAIN_THR == ($past(GAIN_THR) == 4'hA ?
			4'h2 : $past(GAIN_THR) + 4'h1);
	endproperty
	property p_gn_rng; GAIN_THR >= 4'h2 && GAIN_THR <= 4'hA; endproperty
	property p_tone; RUNNING |-> HOLD_TONE; endproperty

	a_rdy: assert property (p_rdy) else $error("ready low");
	a_okay: assert property (p_okay) else $error("error response");
	a_low_rng: assert property (p_low_rng)
		else $error("low threshold out of range");
	a_ladder: assert property (p_ladder)
		else $error("threshold ladder uneven");
	a_step_rng: assert property (p_step_rng)
		else $error("step out of range");
	a_ph_step: assert property (p_ph_step)
		else $error("phase step wrong");
	a_ph_wrap: assert property (p_ph_wrap)
		else $error("phase wrap wrong");
	a_gn_step: assert property (p_gn_step)
		else $error("gain step wrong");
	a_gn_rng: assert property (p_gn_rng)
		else $error("gain out of range");
	a_tone: assert property (p_tone)
		else $error("running without tone");
endmodule // tec_chk

bind tec_top tec_chk chk_i (.MCLK, .RESET, .HREADYOUT, .HRESP,
	.HOLD_TONE, .RUNNING, .IMP_LOW_THR, .IMP_MID_THR, .IMP_HIGH_THR,
	.PHASE_THR, .GAIN_THR);

`default_nettype wire

// *** bench/tec_det_model.sv ***
// detector front end model: hit lines and noise level
`default_nettype none

module tec_det_model (
	input wire logic clk, // system clock
	output logic [5:0] hit, // detector hit levels
	output logic [7:0] nwt // noise-with-tone level
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet lines at start
	initial begin
		hit = 6'h00;
		nwt = 8'h00;
	end

	// n hits on one line, two cycles high, gap plus one cycles low between hits
	task automatic pulse(input int ch, input int n, input int gap);
		repeat (n) begin
			@(posedge clk);
			hit[ch] <= 1'b1;
			repeat (2) @(posedge clk);
			hit[ch] <= 1'b0;
			repeat (gap) @(posedge clk);
		end
	endtask

	// new live noise level
	task set_nwt(input logic [7:0] v);
		@(posedge clk);
		nwt <= v;
	endtask
endmodule // tec_det_model

`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the transient event counter control
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 1'b0;
	logic RESET = 1'b1;
	logic HWRITE = 1'b0;
	logic [1:0] HTRANS = 2'h0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	wire [31:0] HRDATA;
	wire HREADYOUT, HRESP, HOLD_TONE, RUNNING;
	wire [6:0] LO, MID, HI;
	wire [2:0] FLT;
	wire [5:0] PH;
	wire [3:0] GN;
	wire [5:0] hit;
	wire [7:0] nwt;
	int bad_count = 0;
	int tests_run = 0;
	logic [31:0] rd;

	tec_det_model det (.clk(MCLK), .hit(hit), .nwt(nwt));
	// one-second tick shortened to 200 cycles
	tec_top #(.SEC_CYCLES(200)) uut (.MCLK(MCLK), .RESET(RESET),
		.HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.IMP_LO_HIT(hit[0]), .IMP_MID_HIT(hit[1]), .IMP_HI_HIT(hit[2]),
		.PHASE_HIT(hit[3]), .GAIN_HIT(hit[4]), .DROPOUT_HIT(hit[5]),
		.NWT_LEVEL(nwt), .IMP_LOW_THR(LO), .IMP_MID_THR(MID),
		.IMP_HIGH_THR(HI), .IMP_FILTER(FLT), .PHASE_THR(PH),
		.GAIN_THR(GN), .HOLD_TONE(HOLD_TONE), .RUNNING(RUNNING));

	// 50 MHz clock
	initial forever #10 MCLK = ~MCLK;

	task finish_test;
		$display("mismatches %0d checks %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// single word transfer, address then data phase
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge MCLK);
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask

	// key action, then let outputs settle
	task key(input logic [3:0] c, input logic [13:0] v);
		bus(8'h04, 1'b1, {2'h0, v, 12'h0, c});
		@(posedge MCLK);
		#1;
	endtask

	task tm(input logic [13:0] e);
		bus(8'h0C, 1'b0, 32'h0);
		chk(rd[13:0], e);
	endtask

	task t_reset;
		rchk(8'h08, 32'h044C4844);
		rchk(8'h0C, 32'h0A140000);
		rchk(8'h10, 32'h7);
		rchk(8'h34, 32'h0);
		chk(RUNNING, 1'b0);
	endtask

	task t_rate;
		for (int i = 0; i < 3; i++) begin
			key(4'h1, 14'h0);
			rchk(8'h10, i == 0 ? 8 : i == 1 ? 100 : 7);
		end
	endtask

	task t_time;
		key(4'h4, 14'd10);
		key(4'h2, 14'h0);
		tm(14'd15);
		key(4'h3, 14'h0);
		tm(14'd10);
		key(4'h4, 14'd2);
		key(4'h3, 14'h0);
		tm(14'd0);
		key(4'h4, 14'd9997);
		key(4'h2, 14'h0);
		tm(14'd9999);
		key(4'h4, 14'd16000);
		tm(14'd9999);
		key(4'h4, 14'd0);
	endtask

	task t_low;
		key(4'h7, 14'd29);
		chk(LO, 30);
		chk(HI, 38);
		key(4'h6, 14'h0);
		chk(LO, 30);
		key(4'h7, 14'd111);
		key(4'h5, 14'h0);
		chk(LO, 110);
		key(4'h6, 14'h0);
		chk(LO, 109);
		key(4'h7, 14'd68);
	endtask

	task t_cycle;
		for (int i = 0; i < 5; i++) begin
			key(4'h8, 14'h0);
			chk(MID - LO, (i + 3) % 5 + 2);
			chk(HI - MID, (i + 3) % 5 + 2);
		end
		for (int i = 1; i < 10; i++) begin
			key(4'h9, 14'h0);
			chk(PH, (15 + 5 * i) % 45 + 5);
			key(4'hA, 14'h0);
			chk(GN, (i + 8) % 9 + 2);
		end
		key(4'hB, 14'd3);
		chk(FLT, 3);
		key(4'hB, 14'd5);
		chk(FLT, 3);
		chk({PH, GN}, {6'd20, 4'd10});
		key(4'hB, 14'd0);
	endtask

	task t_run;
		logic [31:0] e;
		det.set_nwt(8'h2A);
		repeat (5) @(posedge MCLK);
		rchk(8'h30, 8'h2A);
		bus(8'h00, 1'b1, 32'h2);
		@(posedge MCLK);
		#1;
		chk({HOLD_TONE, RUNNING}, 2'b10);
		bus(8'h00, 1'b1, 32'h3);
		@(posedge MCLK);
		#1;
		chk(RUNNING, 1'b1);
		fork
			det.pulse(3, 10, 3);
			det.pulse(0, 1, 3);
			det.pulse(1, 2, 3);
			det.pulse(2, 3, 3);
			det.pulse(4, 5, 3);
			det.pulse(5, 6, 3);
		join
		det.set_nwt(8'h55);
		repeat (5) @(posedge MCLK);
		rchk(8'h30, 8'h2A);
		for (int i = 0; i < 6; i++)
			rchk(8'h18 + 4 * i, i == 3 ? 7 : i + 1);
		chk(RUNNING, 1'b1);
		key(4'hB, 14'h0);
		rchk(8'h24, 32'h0);
		chk(RUNNING, 1'b1);
		bus(8'h00, 1'b1, 32'h3);
		@(posedge MCLK);
		#1;
		chk(RUNNING, 1'b0);
		bus(8'h14, 1'b0, 32'h0);
		e = rd;
		repeat (300) @(posedge MCLK);
		rchk(8'h14, e);
		rchk(8'h30, 8'h55);
		bus(8'h00, 1'b1, 32'h1);
		@(posedge MCLK);
		#1;
		chk({HOLD_TONE, RUNNING}, 2'b00);
		bus(8'h00, 1'b1, 32'h2);
	endtask

	task t_limit;
		int n;
		n = 0;
		key(4'h4, 14'd1);
		bus(8'h00, 1'b1, 32'h3);
		det.pulse(3, 1, 2);
		chk(RUNNING, 1'b1);
		while (RUNNING === 1'b1 && n < 13000) begin
			@(posedge MCLK);
			n++;
		end
		chk(n > 11800 && n < 12100, 1'b1);
		rchk(8'h24, 32'h1);
		rchk(8'h14, 32'h1);
	endtask

	// reset, then every scenario in turn
	initial begin
		repeat (3) @(posedge MCLK);
		RESET <= 1'b0;
		t_reset();
		t_rate();
		t_time();
		t_low();
		t_cycle();
		t_run();
		t_limit();
		finish_test();
	end

	// hang guard
	initial begin
		repeat (40000) @(posedge MCLK);
		bad_count++;
		finish_test();
	end
endmodule // tb_top

`default_nettype wire
